// File: dv/tb.sv
// testbench for the slot interchange latency control
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb
  import tsi_latency_pkg::*;
;
  logic            clk_in, rst_in, cm_wr, cm_sel, cm_on, run, parity, fwd, rev, self_r;
  logic            strobe, fstrobe;
  logic [3:0][7:0] rx_data, tx_data;
  logic [3:0][1:0] rate;
  logic [1:0]      cm_dst_str, cm_src_str;
  logic [6:0]      cm_dst_slot, cm_src_slot, slot;
  logic [8:0]      lat;
  logic [2:0]      phase;
  int              grid, g0, error_cnt, comparisons;
  int unsigned     rnd_state = 64;
  bit              conn_on [512];
  int              conn_lat [512], conn_src [512];
  int              dv [9] = '{-127, -126, -125, -1, 0, 1, 2, 3, 127};

  tdm_slot_switch_latency #(.NUM_STREAMS(4), .DATA_W(8), .IDLE_DATA(8'hFF)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .slot_strobe_in(strobe), .frame_strobe_in(fstrobe),
    .rx_data_in(rx_data), .rate_in(rate), .cm_wr_in(cm_wr), .cm_dst_str_in(cm_dst_str),
    .cm_dst_slot_in(cm_dst_slot), .cm_src_str_in(cm_src_str), .cm_src_slot_in(cm_src_slot),
    .cm_frame_buffer_select_in(cm_sel), .cm_on_in(cm_on), .tx_data_out(tx_data),
    .slot_out(slot), .frame_parity_out(parity), .lat_pred_out(lat), .fwd_out(fwd),
    .rev_out(rev), .self_route_out(self_r));

  tdm_stream_model #(.NS(4)) model_u (.clk_in(clk_in), .run_in(run), .slot_strobe_out(strobe),
    .frame_strobe_out(fstrobe), .rx_data_out(rx_data), .grid_out(grid), .phase_out(phase));

  function automatic int unsigned rnd();
    rnd_state ^= rnd_state << 13;
    rnd_state ^= rnd_state >> 17;
    rnd_state ^= rnd_state << 5;
    return rnd_state;
  endfunction

  function automatic int lat_f(int d, bit sel, int sd);
    if ((!sel && d == 1) || (sel && d == -127)) return 257;
    if ((!sel && d == 2) || (sel && d == -126)) return sd < 0 ? 258 : 2;
    if (sel) return 128 + d;
    return d > 0 ? d : 256 + d;
  endfunction

  function automatic int shf(int s);
    return rate[s] == 2'h3 ? 0 : int'(rate[s]);
  endfunction

  task automatic cm_write(int ds, int dn, int ss, int sn, bit sel, bit on);
    int dg, sg, key, e;
    dg = dn << shf(ds);
    sg = sn << shf(ss);
    key = ds * 128 + dg;
    e = lat_f(dg - sg, sel, ds - ss);
    if (ds == ss && dg == sg) return;
    cm_dst_str = 2'(ds);
    cm_dst_slot = 7'(dn);
    cm_src_str = 2'(ss);
    cm_src_slot = 7'(sn);
    cm_sel = sel;
    cm_on = on;
    cm_wr = 1'b1;
    @(negedge clk_in) cm_wr = 1'b0;
    @(negedge clk_in);
    conn_on[key] = on;
    conn_lat[key] = e;
    conn_src[key] = ss;
    `CHK("latency", 9'(e), lat)
    `CHK("direction", {dg > sg, dg < sg}, {fwd, rev})
    `CHK("self route", 1'b0, self_r)
  endtask

  task automatic rnd_write();
    int ds, ss;
    ds = rnd() % 4;
    ss = rnd() % 4;
    cm_write(ds, rnd() % (128 >> shf(ds)), ss, rnd() % (128 >> shf(ss)), rnd() % 2,
             rnd() % 8 != 0);
  endtask

  task automatic corner(int d, bit sel, int sd);
    int ss, sn;
    ss = (sd < 0) + rnd() % (4 - (sd != 0));
    sn = (d < 0 ? -d : 0) + rnd() % (128 - (d < 0 ? -d : d));
    cm_write(ss + sd, sn + d, ss, sn, sel, 1'b1);
  endtask

  task automatic check_slot();
    int key;
    logic [7:0] e;
    `CHK("slot", 7'(grid % 128), slot)
    `CHK("parity", 1'((grid / 128) % 2), parity)
    if (grid >= g0) begin
      for (int s = 0; s < 4; s++) begin
        key = s * 128 + grid % 128;
        e = 8'(((grid - conn_lat[key]) * 4 + conn_src[key]) % 251);
        if (!conn_on[key] || grid % (1 << shf(s)) != 0) e = 8'hFF;
        `CHK("tx byte", e, tx_data[s])
      end
    end
  endtask

  task automatic run_slots(int n, int skip);
    g0 = grid + skip;
    run <= 1'b1;
    repeat (n * 8) begin
      @(negedge clk_in);
      if (phase == 3'h6) check_slot();
    end
    run <= 1'b0;
  endtask

  task stop_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // watchdog: about two and a half times the expected run length
  initial begin
    #150000;
    error_cnt++;
    stop_test();
  end

  initial begin
    {rst_in, cm_wr, cm_sel, cm_on, run} = 5'h10;
    {rate, cm_dst_str, cm_src_str, cm_dst_slot, cm_src_slot} = '0;
    repeat (5) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (40) rnd_write();
    for (int p = 0; p < 2; p++) begin
      foreach (dv[i]) for (int sd = -1; sd < 2; sd++) corner(dv[i], p[0], sd);
      run_slots(520, 260);
    end
    // lower stream rates, code 3 included, scaled before the equations
    repeat (4) begin
      rate = 8'(rnd());
      repeat (10) rnd_write();
    end
    // off-grid slots of slower destinations must stay idle
    run_slots(400, 260);
    stop_test();
  end
endmodule

// File: dv/tdm_stream_model.sv
// stream source model: slot and frame strobes with one byte per stream each slot
`timescale 1ns/10ps
module tdm_stream_model #(
  parameter int NS = 4
) (
  input  wire logic          clk_in,
  input  wire logic          run_in,
  output logic               slot_strobe_out,
  output logic               frame_strobe_out,
  output logic [NS-1:0][7:0] rx_data_out,
  output int                 grid_out,
  output logic [2:0]         phase_out
);
  initial begin
    slot_strobe_out = 1'b0;
    frame_strobe_out = 1'b0;
    rx_data_out = '0;
    grid_out = 0;
    phase_out = 3'h0;
  end

  // a slot lasts eight cycles, wider than the minimum strobe spacing
  always @(negedge clk_in) begin
    slot_strobe_out <= 1'b0;
    frame_strobe_out <= 1'b0;
    // bytes are only valid beside the strobe
    rx_data_out <= ~rx_data_out;
    if (run_in) begin
      phase_out <= phase_out + 3'h1;
      if (phase_out == 3'h7) begin
        slot_strobe_out <= 1'b1;
        frame_strobe_out <= ((grid_out + 1) % 128) == 0;
        for (int i = 0; i < NS; i++) rx_data_out[i] <= 8'((grid_out * 4 + i) % 251);
        grid_out <= grid_out + 1;
      end
    end
  end
endmodule

// File: hw/latency_class.sv
// connection classifier: deltas, direction and resulting latency
`timescale 1ns/10ps
module latency_class
  import tsi_latency_pkg::*;
#(
  parameter int STR_W = 2
) (
  input  wire logic [SLOT_W-1:0] dst_slot_in,
  input  wire logic [SLOT_W-1:0] src_slot_in,
  input  wire logic [STR_W-1:0]  dst_str_in,
  input  wire logic [STR_W-1:0]  src_str_in,
  input  wire logic              frame_buffer_select_in,
  output logic      [LAT_W-1:0]  lat_out,
  output logic                   fwd_out,
  output logic                   rev_out,
  output logic                   self_out
);

  logic [DELTA_W-1:0] slot_delta;
  logic [STR_W:0]     str_delta;
  logic [LAT_W-1:0]   delta_ext;
  logic               str_neg;

  always_comb begin
    slot_delta = {1'b0, dst_slot_in} - {1'b0, src_slot_in};
    str_delta  = {1'b0, dst_str_in} - {1'b0, src_str_in};
    delta_ext  = {slot_delta[DELTA_W-1], slot_delta};
    str_neg    = str_delta[STR_W];
    fwd_out    = !slot_delta[DELTA_W-1] && (slot_delta != DELTA_ZERO);
    rev_out    = slot_delta[DELTA_W-1];
    self_out   = (slot_delta == DELTA_ZERO) && (str_delta == '0);
    if (frame_buffer_select_in) begin
      if (slot_delta == DELTA_REV_127) begin
        lat_out = LAT_EXC_LONG;
      end else if (slot_delta == DELTA_REV_126) begin
        lat_out = str_neg ? LAT_EXC_LONGER : LAT_EXC_SHORT;
      end else begin
        // forward constant delay and reverse minimum delay share one form
        lat_out = LAT_ONE_FRAME + delta_ext;
      end
    end else begin
      if (slot_delta == DELTA_FWD_ONE) begin
        lat_out = LAT_EXC_LONG;
      end else if (slot_delta == DELTA_FWD_TWO) begin
        lat_out = str_neg ? LAT_EXC_LONGER : LAT_EXC_SHORT;
      end else if (fwd_out) begin
        lat_out = delta_ext;
      end else begin
        lat_out = LAT_TWO_FRAME + delta_ext;
      end
    end
  end

endmodule

// File: hw/tdm_slot_switch_latency.sv
// double-buffered slot interchange with per-connection latency select
`timescale 1ns/10ps
// Notes on behaviour
// - a connection is forward when the destination slot is above the source, reverse below.
// - slot delta is destination minus source slot, stream delta likewise, both signed.
// - each connection entry holds one buffer-select bit choosing which data buffer is read.
// - forward with select one gives 128 plus the slot delta, for deltas 0 to 127.
// - reverse with select zero gives 256 plus the slot delta, for deltas -127 to -1.
// - forward with select zero gives the slot delta itself, for deltas 3 to 127.
// - reverse with select one gives 128 plus the slot delta, for deltas -125 to -1.
// - delta +1 with select zero or -127 with select one gives 257 whatever the streams.
// - delta +2 with select zero or -126 with select one gives 258 if stream delta is negative, else 2.
// - slot indices of 4.096 and 2.048 Mbit/s streams are scaled by two and four onto the grid.
module tdm_slot_switch_latency
  import tsi_latency_pkg::*;
#(
  parameter int               NUM_STREAMS = 4,
  parameter int               DATA_W      = 8,
  parameter logic [DATA_W-1:0] IDLE_DATA  = 8'hFF
) (
  input  wire logic                                clk_in,
  input  wire logic                                rst_in,
  input  wire logic                                slot_strobe_in,
  input  wire logic                                frame_strobe_in,
  input  wire logic [NUM_STREAMS-1:0][DATA_W-1:0]  rx_data_in,
  input  wire logic [NUM_STREAMS-1:0][1:0]         rate_in,
  input  wire logic                                cm_wr_in,
  input  wire logic [$clog2(NUM_STREAMS)-1:0]      cm_dst_str_in,
  input  wire logic [SLOT_W-1:0]                   cm_dst_slot_in,
  input  wire logic [$clog2(NUM_STREAMS)-1:0]      cm_src_str_in,
  input  wire logic [SLOT_W-1:0]                   cm_src_slot_in,
  input  wire logic                                cm_frame_buffer_select_in,
  input  wire logic                                cm_on_in,
  output logic      [NUM_STREAMS-1:0][DATA_W-1:0]  tx_data_out,
  output logic      [SLOT_W-1:0]                   slot_out,
  output logic                                     frame_parity_out,
  output logic      [LAT_W-1:0]                    lat_pred_out,
  output logic                                     fwd_out,
  output logic                                     rev_out,
  output logic                                     self_route_out
);

  localparam int               STR_W    = $clog2(NUM_STREAMS);
  localparam int               SUB_W    = $clog2(NUM_STREAMS + 2);
  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(NUM_STREAMS + 1);

  typedef struct packed {
    logic [1:0][NUM_STREAMS-1:0][SLOTS-1:0][DATA_W-1:0] dmem;
    logic [NUM_STREAMS-1:0][SLOTS-1:0][STR_W-1:0]        cm_str;
    logic [NUM_STREAMS-1:0][SLOTS-1:0][SLOT_W-1:0]       cm_slot;
    logic [NUM_STREAMS-1:0][SLOTS-1:0]                   cm_sel;
    logic [NUM_STREAMS-1:0][SLOTS-1:0]                   cm_on;
    logic [SLOT_W-1:0]                                   slot;
    logic                                                parity;
    logic [SUB_W-1:0]                                    sub;
    logic [NUM_STREAMS-1:0][DATA_W-1:0]                  cap;
    logic [SLOT_W-1:0]                                   cap_slot;
    logic                                                cap_par;
    logic [NUM_STREAMS-1:0][DATA_W-1:0]                  pend;
    logic [NUM_STREAMS-1:0][DATA_W-1:0]                  tx;
    logic [LAT_W-1:0]                                    lat;
    logic                                                fwd;
    logic                                                rev;
    logic                                                self_route;
  } state_type;

  state_type s_reg;
  state_type s_next;

  logic [SLOT_W-1:0] dst_grid;
  logic [SLOT_W-1:0] src_grid;
  logic [SLOT_W-1:0] next_slot;
  logic [SLOT_W-1:0] read_slot;
  logic              read_par;
  logic [LAT_W-1:0]  cls_lat;
  logic              cls_fwd;
  logic              cls_rev;
  logic              cls_self;

  // map a native slot index onto the 128-slot grid
  function automatic logic [SLOT_W-1:0] to_grid(input logic [1:0] r,
                                                input logic [SLOT_W-1:0] n);
    case (rate_type'(r))
      RATE_4M: to_grid = {n[SLOT_W-2:0], 1'b0};
      RATE_2M: to_grid = {n[SLOT_W-3:0], 2'b00};
      default: to_grid = n;
    endcase
  endfunction

  // a lower-rate stream only occupies every second or fourth grid slot
  function automatic logic on_grid(input logic [1:0] r, input logic [SLOT_W-1:0] g);
    case (rate_type'(r))
      RATE_4M: on_grid = !g[0];
      RATE_2M: on_grid = (g[1:0] == 2'b00);
      default: on_grid = 1'b1;
    endcase
  endfunction

  assign dst_grid = to_grid(rate_in[cm_dst_str_in], cm_dst_slot_in);
  assign src_grid = to_grid(rate_in[cm_src_str_in], cm_src_slot_in);

  latency_class #(
    .STR_W (STR_W)
  ) u_class (
    .dst_slot_in            (dst_grid),
    .src_slot_in            (src_grid),
    .dst_str_in             (cm_dst_str_in),
    .src_str_in             (cm_src_str_in),
    .frame_buffer_select_in (cm_frame_buffer_select_in),
    .lat_out                (cls_lat),
    .fwd_out                (cls_fwd),
    .rev_out                (cls_rev),
    .self_out               (cls_self)
  );

  always_comb begin
    s_next    = s_reg;
    next_slot = frame_strobe_in ? SLOT_FIRST : s_reg.slot + 1'b1;
    // read side works one slot ahead, in the frame of the coming slot
    read_slot = s_reg.slot + 1'b1;
    read_par  = (s_reg.slot == SLOT_LAST) ? !s_reg.parity : s_reg.parity;
    if (slot_strobe_in) begin
      s_next.sub      = '0;
      s_next.cap      = rx_data_in;
      s_next.cap_slot = s_reg.slot;
      s_next.cap_par  = s_reg.parity;
      s_next.slot     = next_slot;
      s_next.tx       = s_reg.pend;
      if (next_slot == SLOT_FIRST) begin
        s_next.parity = !s_reg.parity;
      end
    end else if (s_reg.sub != SUB_LAST) begin
      s_next.sub = s_reg.sub + 1'b1;
    end
    for (int i = 0; i < NUM_STREAMS; i++) begin
      // captured slot lands in the buffer of its own frame one slot later
      if (s_reg.sub == SUB_W'(i)) begin
        s_next.dmem[s_reg.cap_par][i][s_reg.cap_slot] = s_reg.cap[i];
      end
      // reads come one step after the same stream's write and see new contents of that and lower streams, old of higher
      if (s_reg.sub == SUB_W'(i + 1)) begin
        if (s_reg.cm_on[i][read_slot] && on_grid(rate_in[i], read_slot)) begin
          s_next.pend[i] = s_reg.dmem[read_par ^ s_reg.cm_sel[i][read_slot]]
                                     [s_reg.cm_str[i][read_slot]]
                                     [s_reg.cm_slot[i][read_slot]];
        end else begin
          s_next.pend[i] = IDLE_DATA;
        end
      end
    end
    if (cm_wr_in) begin
      s_next.cm_str[cm_dst_str_in][dst_grid]  = cm_src_str_in;
      s_next.cm_slot[cm_dst_str_in][dst_grid] = src_grid;
      s_next.cm_sel[cm_dst_str_in][dst_grid]  = cm_frame_buffer_select_in;
      s_next.cm_on[cm_dst_str_in][dst_grid]   = cm_on_in;
      s_next.lat        = cls_lat;
      s_next.fwd        = cls_fwd;
      s_next.rev        = cls_rev;
      s_next.self_route = cls_self;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tx_data_out      = s_reg.tx;
  assign slot_out         = s_reg.slot;
  assign frame_parity_out = s_reg.parity;
  assign lat_pred_out     = s_reg.lat;
  assign fwd_out          = s_reg.fwd;
  assign rev_out          = s_reg.rev;
  assign self_route_out   = s_reg.self_route;

  // checks on the classifier result registered at each entry write, then on frame swap and output hold
  logic [DELTA_W-1:0] chk_d;
  logic               chk_neg;
  assign chk_d   = {1'b0, dst_grid} - {1'b0, src_grid};
  assign chk_neg = cm_src_str_in > cm_dst_str_in;

  property p_dir;
    @(posedge clk_in) disable iff (rst_in)
    cm_wr_in |=> (fwd_out == (($past(chk_d) != DELTA_ZERO) && !$past(chk_d[DELTA_W-1])))
                 && (rev_out == $past(chk_d[DELTA_W-1]));
  endproperty
  a_dir: assert property (p_dir) else $error("direction flags wrong");

  property p_cd_fwd;
    @(posedge clk_in) disable iff (rst_in)
    cm_wr_in && cm_frame_buffer_select_in && !chk_d[DELTA_W-1]
      |=> lat_pred_out == LAT_ONE_FRAME + {1'b0, $past(chk_d)};
  endproperty
  a_cd_fwd: assert property (p_cd_fwd) else $error("forward constant delay wrong");

  property p_cd_rev;
    @(posedge clk_in) disable iff (rst_in)
    cm_wr_in && !cm_frame_buffer_select_in && chk_d[DELTA_W-1]
      |=> lat_pred_out == LAT_TWO_FRAME + {1'b1, $past(chk_d)};
  endproperty
  a_cd_rev: assert property (p_cd_rev) else $error("reverse constant delay wrong");

  property p_md_fwd;
    @(posedge clk_in) disable iff (rst_in)
    cm_wr_in && !cm_frame_buffer_select_in && !chk_d[DELTA_W-1] && chk_d >= DELTA_MIN_FWD
      |=> lat_pred_out == {1'b0, $past(chk_d)};
  endproperty
  a_md_fwd: assert property (p_md_fwd) else $error("forward minimum delay wrong");

  property p_md_rev;
    @(posedge clk_in) disable iff (rst_in)
    cm_wr_in && cm_frame_buffer_select_in && chk_d >= DELTA_MIN_REV
      |=> lat_pred_out == LAT_ONE_FRAME + {1'b1, $past(chk_d)};
  endproperty
  a_md_rev: assert property (p_md_rev) else $error("reverse minimum delay wrong");

  property p_exc_one;
    @(posedge clk_in) disable iff (rst_in)
    cm_wr_in && ((!cm_frame_buffer_select_in && chk_d == DELTA_FWD_ONE)
              || (cm_frame_buffer_select_in && chk_d == DELTA_REV_127))
      |=> lat_pred_out == LAT_EXC_LONG;
  endproperty
  a_exc_one: assert property (p_exc_one) else $error("257 slot case wrong");

  property p_exc_two;
    @(posedge clk_in) disable iff (rst_in)
    cm_wr_in && ((!cm_frame_buffer_select_in && chk_d == DELTA_FWD_TWO)
              || (cm_frame_buffer_select_in && chk_d == DELTA_REV_126))
      |=> lat_pred_out == ($past(chk_neg) ? LAT_EXC_LONGER : LAT_EXC_SHORT);
  endproperty
  a_exc_two: assert property (p_exc_two) else $error("258 or 2 slot case wrong");

  property p_swap;
    @(posedge clk_in) disable iff (rst_in)
    slot_strobe_in && frame_strobe_in |=> frame_parity_out != $past(frame_parity_out);
  endproperty
  a_swap: assert property (p_swap) else $error("buffers did not swap at frame");

  property p_tx_hold;
    @(posedge clk_in) disable iff (rst_in)
    !slot_strobe_in |=> $stable(tx_data_out) && $stable(slot_out);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("output changed inside a slot");

endmodule

// File: pkg/tsi_latency_pkg.sv
// shared constants and types for the slot interchange latency control
package tsi_latency_pkg;

  localparam int          SLOTS    = 128;
  localparam int          SLOT_W   = 7;
  localparam int          DELTA_W  = 8;
  localparam int          LAT_W    = 9;

  localparam logic [SLOT_W-1:0] SLOT_FIRST = 7'h00;
  localparam logic [SLOT_W-1:0] SLOT_LAST  = 7'h7F;

  // latencies in slots of the 8.192 Mbit/s grid
  localparam logic [LAT_W-1:0] LAT_ONE_FRAME  = 9'h080;
  localparam logic [LAT_W-1:0] LAT_TWO_FRAME  = 9'h100;
  localparam logic [LAT_W-1:0] LAT_EXC_LONG   = 9'h101;
  localparam logic [LAT_W-1:0] LAT_EXC_LONGER = 9'h102;
  localparam logic [LAT_W-1:0] LAT_EXC_SHORT  = 9'h002;

  // slot deltas, two's complement
  localparam logic [DELTA_W-1:0] DELTA_ZERO     = 8'h00;
  localparam logic [DELTA_W-1:0] DELTA_FWD_ONE  = 8'h01;
  localparam logic [DELTA_W-1:0] DELTA_FWD_TWO  = 8'h02;
  localparam logic [DELTA_W-1:0] DELTA_MIN_FWD  = 8'h03;
  localparam logic [DELTA_W-1:0] DELTA_REV_127  = 8'h81;
  localparam logic [DELTA_W-1:0] DELTA_REV_126  = 8'h82;
  localparam logic [DELTA_W-1:0] DELTA_MIN_REV  = 8'h83;

  // stream rate codes; the code is also the slot scaling shift
  typedef enum logic [1:0] {
    RATE_8M = 2'h0,
    RATE_4M = 2'h1,
    RATE_2M = 2'h2
  } rate_type;

endpackage
